// >>> hw/idw_pkg.sv
// Constants for the identify-data words 88 to 96 and their APB configuration registers.
// Assumes a 32-bit APB with word-aligned registers; byte address is four times the index.
//
// Contract
// - Low byte of word 88 reports Ultra DMA modes 0-6 supported, reads 7F.
// - High byte of word 88 shows the active Ultra DMA mode; bit 15 zero.
// - Erase time word: bit 15 picks 15-bit time, else 8-bit time, 14:8 zero.
// - Normal erase time field times two gives minutes.
// - Word 90 reports enhanced erase time with the same format choice.
// - Word 91 returns the current power level, default 00FE.
// - Word 92 returns the password revision code FFFE.
// - Word 95 gives streaming request size, power of two, at least eight.
// - Word 96 times granularity over 65536 gives streaming transfer time.
// - Word 96 reads zero when streaming is not supported.
// - Words 98 and 99 hold the streaming granularity value; here it sits only in config registers 87h and 88h.
// - Streaming support bit 4 decides whether streaming words are nonzero.
package idw_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;

  // Word indices of the identify words
  localparam logic [7:0] IDX_UDMA = 8'h58;
  localparam logic [7:0] IDX_ERASE_N = 8'h59;
  localparam logic [7:0] IDX_ERASE_E = 8'h5a;
  localparam logic [7:0] IDX_POWER = 8'h5b;
  localparam logic [7:0] IDX_PWREV = 8'h5c;
  localparam logic [7:0] IDX_LINKRST = 8'h5d;
  localparam logic [7:0] IDX_RSVD = 8'h5e;
  localparam logic [7:0] IDX_STREQ = 8'h5f;
  localparam logic [7:0] IDX_XFER = 8'h60;

  // Word indices of the firmware configuration and status registers
  localparam logic [7:0] IDX_CFG_UDMA = 8'h80;
  localparam logic [7:0] IDX_CFG_ERASE_N = 8'h81;
  localparam logic [7:0] IDX_CFG_ERASE_E = 8'h82;
  localparam logic [7:0] IDX_CFG_POWER = 8'h83;
  localparam logic [7:0] IDX_CFG_PWREV = 8'h84;
  localparam logic [7:0] IDX_CFG_STREAM = 8'h85;
  localparam logic [7:0] IDX_CFG_XFER = 8'h86;
  localparam logic [7:0] IDX_CFG_GRAN_LO = 8'h87;
  localparam logic [7:0] IDX_CFG_GRAN_HI = 8'h88;
  localparam logic [7:0] IDX_STATUS = 8'h89;

  // Reset values
  localparam logic [15:0] RST_POWER = 16'h00FE;
  localparam logic [15:0] RST_PWREV = 16'hFFFE;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [3:0] RST_UDMA_CFG = 4'h0;
  localparam logic [4:0] RST_STREAM_CFG = 5'h03;

  // Field positions and values
  localparam logic [7:0] UDMA_SUPPORTED = 8'h7F;
  localparam logic [2:0] UDMA_MODE_MAX = 3'h6;
  localparam int unsigned UDMA_ACT_EN_BIT = 3;
  localparam int unsigned ERASE_EXT_BIT = 15;
  localparam logic [16:0] ERASE_SHORT_MAX = 17'h0_00FF;
  localparam logic [16:0] ERASE_EXT_MAX = 17'h0_7FFF;
  localparam int unsigned STREAM_SUP_BIT = 4;
  localparam logic [3:0] STREAM_LOG2_MIN = 4'h3;
  localparam int unsigned XFER_SCALE = 65536;

  // Status register bit positions
  localparam int unsigned ST_STREAM_SUP = 0;
  localparam int unsigned ST_UDMA_ACTIVE = 1;
  localparam int unsigned ST_ERASE_N_EXT = 2;
  localparam int unsigned ST_ERASE_E_EXT = 3;
  localparam int unsigned ST_STREQ_CLAMP = 4;
  localparam int unsigned ST_UDMA_BADMODE = 5;

endpackage : idw_pkg

// >>> hw/idw_identify_mid.sv
// APB register bank that serves identify-data words 88 to 96 and their config.
// Assumes an APB4 master on the same clock; drive firmware fills the config registers,
// the link logic reads the identify words at their own addresses below the config block.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module idw_identify_mid
  import idw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [WORD_W-1:0] powerLevelSetting,
  output logic [6:0] udmaActiveOneHot,
  output logic streamingSupported
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Minutes to erase-time word; rounds up to whole two-minute units
  function automatic logic [15:0] eraseWord(input logic [15:0] minutes);
    logic [16:0] units;
    units = ({1'b0, minutes} + 17'h0_0001) >> 1;
    if (units <= ERASE_SHORT_MAX) begin
      eraseWord = {8'h00, units[7:0]};
    end else if (units > ERASE_EXT_MAX) begin
      eraseWord = 16'hFFFF; // Saturate rather than wrap
    end else begin
      eraseWord = {1'b1, units[14:0]};
    end
  endfunction : eraseWord

  // Whether a minutes value needs the extended format
  function automatic logic eraseIsExt(input logic [15:0] minutes);
    logic [15:0] w;
    w = eraseWord(minutes);
    eraseIsExt = w[ERASE_EXT_BIT];
  endfunction : eraseIsExt

  // Mode number to one-hot; modes past 6 give no active bit
  function automatic logic [6:0] udmaOneHot(input logic [3:0] cfg);
    udmaOneHot = 7'h00;
    if (cfg[UDMA_ACT_EN_BIT] && (cfg[2:0] <= UDMA_MODE_MAX)) begin
      udmaOneHot = 7'h01 << cfg[2:0];
    end
  endfunction : udmaOneHot

  // Clamp of the request-size exponent to the eight-sector floor
  function automatic logic [3:0] streqLog2(input logic [3:0] raw);
    streqLog2 = (raw < STREAM_LOG2_MIN) ? STREAM_LOG2_MIN : raw;
  endfunction : streqLog2

  // Byte-lane merge of a 16-bit config register
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] strb
  );
    laneMerge = old;
    if (strb[0]) begin
      laneMerge[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      laneMerge[15:8] = wd[15:8];
    end
  endfunction : laneMerge

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase decode

  // Decoded view of the current APB cycle
  logic [7:0] index;
  logic alignedOk;
  logic setupPhase;
  logic accessPhase;
  logic writeCommit;

  // Upper address bits beyond the index must be zero, low two bits ignored
  assign index = paddr[9:2];
  assign alignedOk = (paddr[ADDR_W-1:10] == 2'b00);
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  // Zero wait states, so every access phase completes at once
  assign pready = accessPhase;
  assign writeCommit = accessPhase && pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by drive firmware

  // Raw settings; the identify words are built from all of these but the two granularity registers
  logic [3:0] udmaCfg_reg;
  logic [15:0] eraseNormMin_reg;
  logic [15:0] eraseEnhMin_reg;
  logic [15:0] power_reg;
  logic [15:0] pwRev_reg;
  logic [4:0] streamCfg_reg;
  logic [15:0] xferTime_reg;
  logic [15:0] granLo_reg;
  logic [15:0] granHi_reg;
  logic cfgWriteHit;

  assign cfgWriteHit = writeCommit && alignedOk;

  // Active Ultra DMA mode selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      udmaCfg_reg <= RST_UDMA_CFG;
    end else if (cfgWriteHit && (index == IDX_CFG_UDMA) && pstrb[0]) begin
      udmaCfg_reg <= pwdata[3:0];
    end
  end

  // Normal erase duration in minutes; the word format is derived, not stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eraseNormMin_reg <= RST_ZERO;
    end else if (cfgWriteHit && (index == IDX_CFG_ERASE_N)) begin
      eraseNormMin_reg <= laneMerge(eraseNormMin_reg, pwdata, pstrb);
    end
  end

  // Enhanced erase duration in minutes, same scheme as the normal one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eraseEnhMin_reg <= RST_ZERO;
    end else if (cfgWriteHit && (index == IDX_CFG_ERASE_E)) begin
      eraseEnhMin_reg <= laneMerge(eraseEnhMin_reg, pwdata, pstrb);
    end
  end

  // Power level; firmware updates it when the host changes the setting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_reg <= RST_POWER;
    end else if (cfgWriteHit && (index == IDX_CFG_POWER)) begin
      power_reg <= laneMerge(power_reg, pwdata, pstrb);
    end
  end

  // Password revision; stays at its reset code unless firmware overrides it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwRev_reg <= RST_PWREV;
    end else if (cfgWriteHit && (index == IDX_CFG_PWREV)) begin
      pwRev_reg <= laneMerge(pwRev_reg, pwdata, pstrb);
    end
  end

  // Streaming support bit and request-size exponent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      streamCfg_reg <= RST_STREAM_CFG;
    end else if (cfgWriteHit && (index == IDX_CFG_STREAM) && pstrb[0]) begin
      streamCfg_reg <= pwdata[4:0];
    end
  end

  // Transfer time and granularity, kept together since they scale each other
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xferTime_reg <= RST_ZERO;
      granLo_reg <= RST_ZERO;
      granHi_reg <= RST_ZERO;
    end else if (cfgWriteHit) begin
      if (index == IDX_CFG_XFER) begin
        xferTime_reg <= laneMerge(xferTime_reg, pwdata, pstrb);
      end
      if (index == IDX_CFG_GRAN_LO) begin
        granLo_reg <= laneMerge(granLo_reg, pwdata, pstrb);
      end
      if (index == IDX_CFG_GRAN_HI) begin
        granHi_reg <= laneMerge(granHi_reg, pwdata, pstrb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Identify word assembly

  // Intermediate values, one per identify slot
  logic streamOn;
  logic [6:0] udmaAct;
  logic [3:0] streqExp;
  logic [15:0] wordUdma;
  logic [15:0] wordEraseN;
  logic [15:0] wordEraseE;
  logic [15:0] wordStreq;
  logic [15:0] wordXfer;
  logic [15:0] wordStatus;

  assign streamOn = streamCfg_reg[STREAM_SUP_BIT];
  assign udmaAct = udmaOneHot(udmaCfg_reg);
  assign streqExp = streqLog2(streamCfg_reg[3:0]);

  // Reserved bits 15 and 7 forced low by construction
  assign wordUdma = {1'b0, udmaAct, UDMA_SUPPORTED};
  assign wordEraseN = eraseWord(eraseNormMin_reg);
  assign wordEraseE = eraseWord(eraseEnhMin_reg);
  // Power of two only; the host aligns its start LBA to this size
  assign wordStreq = streamOn ? (16'h0001 << streqExp) : RST_ZERO;
  // Raw value; the host scales by granularity over 65536
  assign wordXfer = streamOn ? xferTime_reg : RST_ZERO;

  // Firmware-visible summary of how the words were built
  always_comb begin
    wordStatus = RST_ZERO;
    wordStatus[ST_STREAM_SUP] = streamOn;
    wordStatus[ST_UDMA_ACTIVE] = |udmaAct;
    wordStatus[ST_ERASE_N_EXT] = eraseIsExt(eraseNormMin_reg);
    wordStatus[ST_ERASE_E_EXT] = eraseIsExt(eraseEnhMin_reg);
    wordStatus[ST_STREQ_CLAMP] = (streamCfg_reg[3:0] < STREAM_LOG2_MIN);
    wordStatus[ST_UDMA_BADMODE] = udmaCfg_reg[UDMA_ACT_EN_BIT]
                                  && (udmaCfg_reg[2:0] > UDMA_MODE_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and error decode

  // Selected word and whether the index is mapped
  logic [15:0] readWord;
  logic readHit;
  logic writeOk;

  // Identify words are readable only; config is read-write; status read-only
  always_comb begin
    readWord = RST_ZERO;
    readHit = 1'b1;
    writeOk = 1'b0;
    case (index)
      IDX_UDMA: readWord = wordUdma;
      IDX_ERASE_N: readWord = wordEraseN;
      IDX_ERASE_E: readWord = wordEraseE;
      IDX_POWER: readWord = power_reg;
      IDX_PWREV: readWord = pwRev_reg;
      IDX_LINKRST: readWord = RST_ZERO;
      IDX_RSVD: readWord = RST_ZERO;
      IDX_STREQ: readWord = wordStreq;
      IDX_XFER: readWord = wordXfer;
      IDX_CFG_UDMA: begin
        readWord = {12'h000, udmaCfg_reg};
        writeOk = 1'b1;
      end
      IDX_CFG_ERASE_N: begin
        readWord = eraseNormMin_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_ERASE_E: begin
        readWord = eraseEnhMin_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_POWER: begin
        readWord = power_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_PWREV: begin
        readWord = pwRev_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_STREAM: begin
        readWord = {11'h000, streamCfg_reg};
        writeOk = 1'b1;
      end
      IDX_CFG_XFER: begin
        readWord = xferTime_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_GRAN_LO: begin
        readWord = granLo_reg;
        writeOk = 1'b1;
      end
      IDX_CFG_GRAN_HI: begin
        readWord = granHi_reg;
        writeOk = 1'b1;
      end
      IDX_STATUS: readWord = wordStatus;
      default: readHit = 1'b0;
    endcase
    if (!alignedOk) begin
      readWord = RST_ZERO;
      readHit = 1'b0;
      writeOk = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered answer, captured in the setup cycle

  // Answer as it would stand if this were the setup cycle
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_next;

  // Upper half always zero; a write returns zero data
  assign prdata_next = pwrite ? 32'h0000_0000 : {16'h0000, readWord};
  // Write to a read-only word or any unmapped access is refused
  assign pslverr_next = pwrite ? !writeOk : !readHit;

  // Captured one cycle early so the access phase answers with flop outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= prdata_next;
      pslverr <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Side outputs toward the rest of the controller

  // Power level copy; one cycle behind the register, so downstream sees a flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      powerLevelSetting <= RST_POWER;
    end else begin
      powerLevelSetting <= power_reg;
    end
  end

  // Active mode one-hot for the link layer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      udmaActiveOneHot <= 7'h00;
    end else begin
      udmaActiveOneHot <= udmaAct;
    end
  end

  // Streaming support flag for the command decoder
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      streamingSupported <= 1'b0;
    end else begin
      streamingSupported <= streamOn;
    end
  end

endmodule : idw_identify_mid

// >>> sim/idw_host_model.sv
// Host-side APB master standing in for the link controller.
// Assumes calls to xfer come from one process only.
`timescale 1ns/1ps
module idw_host_model (
  input wire logic clk,
  input wire logic pready,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  ////////////////////////////////////////
  // Bus idles deselected from time zero
  initial begin
    {psel, penable, pwrite, pstrb} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Stream starts sit on a multiple of the request size
  function automatic logic [47:0] stream_start(input logic [47:0] lba, input logic [15:0] sz);
    return lba & ~(48'(sz) - 48'h0000_0000_0001);
  endfunction : stream_start

  // Setup, then access until pready; on release address and write data flip so stale data never matches
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : idw_host_model

// >>> sim/idw_identify_mid_sva.sv
// Port checker for the identify-word bank.
// Assumes zero-wait APB, read data captured in the setup cycle.
`timescale 1ns/1ps
module idw_identify_mid_chk
  import idw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WORD_W-1:0] powerLevelSetting,
  input wire logic [6:0] udmaActiveOneHot,
  input wire logic streamingSupported
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic rdAcc;

  ////////////////////////////////////////
  // Read in its access cycle
  assign rdAcc = psel && penable && !pwrite;

  // Handshake and refusals
  chk_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready not tied to access");
  chk_ro_refused: assert property (
    psel && penable && pwrite && paddr inside {[12'h160:12'h180]} |-> pslverr)
    else $error("identify write not refused");
  // Identify word contents
  chk_udma_low: assert property (
    rdAcc && paddr == 12'h160 |-> prdata[7:0] == 8'h7F && prdata[31:16] == 16'h0000)
    else $error("supported modes wrong");
  chk_udma_active: assert property (
    rdAcc && paddr == 12'h160 |-> !prdata[15] && $onehot0(prdata[14:8]))
    else $error("active mode field wrong");
  chk_erase_format: assert property (
    rdAcc && paddr inside {12'h164, 12'h168} |-> prdata[15] || prdata[14:8] == 7'h00)
    else $error("erase word reserved bits set");
  chk_power_copy: assert property (
    rdAcc && paddr == 12'h16C |-> prdata[15:0] == powerLevelSetting)
    else $error("power word and port differ");
  chk_power_reset: assert property ($fell(reset) |-> powerLevelSetting == 16'h00FE)
    else $error("power level reset value wrong");
  chk_zero_words: assert property (
    rdAcc && paddr inside {12'h174, 12'h178} |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("zero word not zero");
  chk_stream_size: assert property (
    rdAcc && paddr == 12'h17C && streamingSupported == $past(streamingSupported) |->
    (streamingSupported ? $onehot(prdata) && prdata[2:0] == 3'h0 : prdata == 32'h0000_0000))
    else $error("request size word wrong");
  chk_xfer_off: assert property (
    rdAcc && paddr == 12'h180 && !streamingSupported && !$past(streamingSupported) |->
    prdata == 32'h0000_0000)
    else $error("transfer time nonzero without streaming");
endmodule : idw_identify_mid_chk

bind idw_identify_mid idw_identify_mid_chk i_idw_identify_mid_chk (.clk, .reset, .paddr,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .powerLevelSetting,
  .udmaActiveOneHot, .streamingSupported);

// >>> sim/tb_top.sv
// Self-checking bench for the identify-word bank over APB.
// Assumes the host model as sole bus master.
`timescale 1ns/1ps
module tb_top
  import idw_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, streamingSupported, s, eExt;
  logic [47:0] lba;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] powerLevelSetting, d, sz;
  logic [6:0] udmaActiveOneHot;
  logic [32:0] expQ[$];
  int errTotal = 0, comparisons = 0, cycles = 0;
  int mins[8] = '{0, 1, 2, 509, 510, 511, 65534, 65535};
  logic [15:0] rst[9] = '{16'h007F, 16'h0000, 16'h0000, 16'h00FE, 16'hFFFE, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};

  idw_identify_mid i_idw_identify_mid (.clk, .reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .powerLevelSetting, .udmaActiveOneHot,
    .streamingSupported);
  idw_host_model i_idw_host_model (.clk, .pready, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb);

  ////////////////////////////////////////
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Answers are noted first; upper write bits are noise the bank must ignore
  task automatic rd(input logic [11:0] a, input logic [15:0] v, input logic e);
    expQ.push_back({e, 16'h0000, v});
    i_idw_host_model.xfer(a, 1'b0, 32'h0000_0000, 4'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [3:0] b,
                    input logic e);
    expQ.push_back({e, 32'h0000_0000});
    i_idw_host_model.xfer(a, 1'b1, {16'($urandom), v}, b);
  endtask : wr

  // Minutes round up to two-minute units; long form up to 7FFF units
  function automatic logic [15:0] erase_word(input logic [15:0] m);
    int u;
    u = (int'(m) + 1) / 2;
    if (u <= 255) return 16'(u);
    if (u <= 32767) return 16'h8000 | 16'(u);
    return 16'hFFFF;
  endfunction : erase_word

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Each completed transfer retires the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      if (expQ.size() == 0) check(33'h1_FFFF_FFFF, 33'h0_0000_0000);
      else check({pslverr, prdata}, expQ.pop_front());
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errTotal++;
      $display("[FAIL] %0t: timeout", $time);
      finish_test();
    end
  end

  initial begin
    reset = 1'b1;
    void'($urandom(79));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) rd(12'h160 + 12'(4 * i), rst[i], 1'b0);
    check(33'(powerLevelSetting), 33'h0_0000_00FE);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(12'h200, 16'(8 + i), 4'h1, 1'b0);
      rd(12'h160, {1'b0, i < 7 ? 7'(1 << i) : 7'h00, 8'h7F}, 1'b0);
      check(33'(udmaActiveOneHot), 33'(i < 7 ? 7'(1 << i) : 7'h00));
      rd(12'h224, i < 7 ? 16'h0002 : 16'h0020, 1'b0);
    end
    wr(12'h200, 16'h0002, 4'h1, 1'b0);
    rd(12'h160, 16'h007F, 1'b0);
    $display("test transfer modes done");
    for (int j = 0; j < 10; j++) begin
      d = j < 8 ? 16'(mins[j]) : 16'($urandom);
      for (int k = 0; k < 2; k++) begin
        wr(12'h204 + 12'(4 * k), d, 4'h3, 1'b0);
        rd(12'h164 + 12'(4 * k), erase_word(d), 1'b0);
      end
      // Above 510 minutes the unit count no longer fits the short format
      eExt = d > 16'h01FE;
      rd(12'h224, {12'h000, eExt, eExt, 2'b00}, 1'b0);
    end
    $display("test erase times done");
    d = 16'($urandom);
    wr(12'h20C, d, 4'hF, 1'b0);
    wr(12'h20C, ~d, 4'h1, 1'b0);
    wr(12'h210, ~d, 4'hF, 1'b0);
    rd(12'h170, ~d, 1'b0);
    for (int i = 0; i < 10; i++) begin
      wr(i < 9 ? 12'h160 + 12'(4 * i) : 12'h224, 16'h1234, 4'hF, 1'b1);
    end
    rd(12'h16C, {d[15:8], ~d[7:0]}, 1'b0);
    check(33'(powerLevelSetting), 33'({d[15:8], ~d[7:0]}));
    rd(12'h184, 16'h0000, 1'b1);
    rd(12'h560, 16'h0000, 1'b1);
    $display("test power and refusals done");
    for (int i = 0; i < 17; i++) begin
      s = i < 16;
      d = 16'($urandom);
      sz = 16'(1 << (i < 3 ? 3 : i));
      wr(12'h218, d, 4'h3, 1'b0);
      wr(12'h214, {11'h000, s, 4'(i)}, 4'h1, 1'b0);
      rd(12'h17C, s ? sz : 16'h0000, 1'b0);
      rd(12'h180, s ? d : 16'h0000, 1'b0);
      rd(12'h224, {11'h000, (i < 3 || i == 16), eExt, eExt, 1'b0, s}, 1'b0);
      check(33'(streamingSupported), 33'(s));
      // Host places its stream starts on a multiple of the advertised size
      lba = i_idw_host_model.stream_start(48'({$urandom, $urandom}), sz);
      if (s) check(33'(lba % 48'(sz)), 33'h0_0000_0000);
    end
    wr(12'h21C, d, 4'h3, 1'b0);
    wr(12'h220, ~d, 4'h3, 1'b0);
    rd(12'h21C, d, 1'b0);
    rd(12'h220, ~d, 1'b0);
    $display("test streaming done");
    // Mid-run reset must bring the firmware settings back to their defaults
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(12'h16C, 16'h00FE, 1'b0);
    rd(12'h170, 16'hFFFE, 1'b0);
    rd(12'h17C, 16'h0000, 1'b0);
    check(33'(powerLevelSetting), 33'h0_0000_00FE);
    $display("test second reset done");
    repeat (2) @(posedge clk);
    check(33'(expQ.size()), 33'h0_0000_0000);
    finish_test();
  end
endmodule : tb_top
